// ### sdio_pkg.sv
/*
 package for the stepper driver control-side i/o logic: mode codes, alarm codes and widths.
 assumes a single 200 MHz clock domain; no registers, every setting arrives on a port.
*/
package sdio_pkg;
	// input mode selection values
	localparam logic IO_MODE_POSITION = 1'h0;
	localparam logic IO_MODE_PUSH = 1'h1;
	// alarm code output enable values
	localparam logic ALM_CODE_DISABLE = 1'h0;
	localparam logic ALM_CODE_ENABLE = 1'h1;
	// widths
	localparam int POS_W = 32;
	localparam int PUSH_SEL_W = 3;
	localparam int ALM_CODE_W = 3;
	localparam int RES_CODE_W = 1;
	// resolution selectors: first (switch-off table) or second (switch-on table)
	localparam logic RES_SEL_FIRST = 1'h0;
	localparam logic RES_SEL_SECOND = 1'h1;
	// factory resolution figures in pulses per revolution
	localparam int RES_FIRST_P_R = 1000;
	localparam int RES_FIRST_ALT_P_R = 500;
	localparam int RES_SECOND_P_R = 10000;
	localparam int RES_SECOND_ALT_P_R = 5000;
	// degrees per step-timing mark, in tenths of a degree
	localparam int TIM_STEP_DDEG = 72;
	// default completion window, tenths of a degree
	localparam int END_WINDOW_DDEG = 18;
	// clock
	localparam int CLK_MHZ = 200;
	// home value of accumulated command position
	localparam logic [31:0] HOME_POS = 32'h0000_0000;
	// return-to-home state codes
	typedef enum logic [2:0] {
		SDIO_RET_IDLE = 3'h1,
		SDIO_RET_RUN = 3'h2,
		SDIO_RET_BLOCK = 3'h4
	} sdio_ret_t;
endpackage

// ### sdio_sync.sv
/*
 two-flop synchroniser with rise and fall detection for opto-isolated inputs.
 assumes inputs are asynchronous levels where high means the photocoupler conducts.
*/
`timescale 1ns/100ps
`default_nettype none
module sdio_sync #(
	parameter int W = 1
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] level_out,
	output logic [W-1:0] rise_out,
	output logic [W-1:0] fall_out
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] sync_ff;
	logic [W-1:0] prev_ff;

	// first stage only feeds the second stage
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			meta_ff <= '0;
			sync_ff <= '0;
			prev_ff <= '0;
		end else begin
			meta_ff <= async_in;
			sync_ff <= meta_ff;
			prev_ff <= sync_ff;
		end
	end

	// edges come from the settled stages
	assign level_out = sync_ff;
	assign rise_out = sync_ff & ~prev_ff;
	assign fall_out = ~sync_ff & prev_ff;
endmodule
`default_nettype wire

// ### sdio_top.sv
/*
 control-side input decoding and status outputs of a pulse-input stepping motor driver.
 assumes motor-side logic supplies step strobes, position and deviation figures, torque,
 alarm and warning conditions on the same clock; opto inputs arrive asynchronously.
*/
// Notes on behaviour
// - lock switch off: select input low picks first resolution, high picks second.
// - lock switch on: select input ignored, second resolution kept.
// - select asserted with warning enabled blocks homing; preset then go-home re-enables.
// - push mode: push current mode input switches drive to selected push current.
// - shared pins mean positioning functions or push functions per input mode.
// - go-home input starts move to position where command count equals zero.
// - home preset clears command position to zero; host uses it at standstill.
// - deviation clear input resets position deviation counter to zero.
// - step pulses are ignored while deviation clear input is asserted.
// - deviation clear aborts automatic return and return-to-home in progress.
// - resettable alarm clears on falling edge of alarm reset; alarm output on.
// - alarm turns alarm output off, cuts current, stops; data alarms keep current.
// - current-control select enters current mode unless disable switch on.
// - ready only with power, no start inputs, excite, no stop, alarm or tool.
// - code enabled and alarm active: ready, torque and open-collector timing outputs carry code.
// - torque flag on when torque out of range, and throughout pushing.
// - move-done when no pulses and rotor within configurable window of command.
// - step-timing outputs on once per 7.2 degrees, rate-limited per output kind.
// - quadrature phases A and B, B lagging ninety degrees, give direction.
// - warning output on when a warning condition occurs.
// - three push-select bits choose one of eight push current settings.
// - input mode value 0 is positioning, 1 is push-motion.
// - alarm code output enable bit: 0 disables, 1 enables.
`timescale 1ns/100ps
`default_nettype none
module sdio_top
	import sdio_pkg::*;
#(
	parameter int POS_WIDTH = POS_W
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	// opto-isolated inputs, high while conducting
	input wire logic shared_sel_in,
	input wire logic shared_bit1_in,
	input wire logic shared_bit2_in,
	input wire logic push_select_bit0_in,
	input wire logic deviation_clear_in,
	input wire logic current_control_select_in,
	input wire logic excite_on_in,
	input wire logic stop_in,
	input wire logic start_inputs_any_in,
	// switches and configuration
	input wire logic resolution_lock_switch_in,
	input wire logic current_mode_disable_switch_in,
	input wire logic io_mode_in,
	input wire logic alarm_code_enable_in,
	input wire logic abnormal_data_warn_enable_in,
	input wire logic power_good_in,
	input wire logic tool_busy_in,
	// motor-side status, same clock
	input wire logic step_pulse_in,
	input wire logic step_dir_in,
	input wire logic pulse_active_in,
	input wire logic [POS_WIDTH-1:0] rotor_error_in,
	input wire logic [POS_WIDTH-1:0] end_window_in,
	input wire logic [POS_WIDTH-1:0] end_offset_in,
	input wire logic torque_over_in,
	input wire logic pushing_in,
	input wire logic alarm_event_in,
	input wire logic alarm_resettable_in,
	input wire logic alarm_data_kind_in,
	input wire logic [ALM_CODE_W-1:0] alarm_cause_in,
	input wire logic warning_cond_in,
	input wire logic motor_tick_in,
	input wire logic motor_dir_in,
	input wire logic auto_return_active_in,
	input wire logic home_reached_in,
	input wire logic tim_mark_in,
	input wire logic tim_line_ok_in,
	input wire logic tim_oc_ok_in,
	// outputs
	output logic resolution_second_out,
	output logic push_current_active_out,
	output logic [PUSH_SEL_W-1:0] push_select_out,
	output logic current_control_mode_out,
	output logic go_home_run_out,
	output logic abort_return_out,
	output logic motor_current_cut_out,
	output logic [POS_WIDTH-1:0] command_pos_out,
	output logic [POS_WIDTH-1:0] deviation_out,
	output logic ready_out,
	output logic torque_limit_flag_out,
	output logic move_done_out,
	output logic step_timing_line_out,
	output logic step_timing_oc_out,
	output logic feedback_phase_a_out,
	output logic feedback_phase_b_out,
	output logic alarm_n_out,
	output logic warning_flag_out
);
	localparam int NOPTO = 8;

	logic [NOPTO-1:0] opto_raw;
	logic [NOPTO-1:0] opto_lvl;
	logic [NOPTO-1:0] opto_rise;
	logic [NOPTO-1:0] opto_fall;
	logic sel_l, b1_l, b2_l, b1_r, b2_r, sel_r;
	logic clr_l, clr_r, clr_f, ccm_l, exc_l, stp_l;
	logic push_mode;
	logic alarm_ff, alarm_resettable_ff;
	logic [1:0] quad_ff;
	logic ret_block_ff;
	sdio_ret_t ret_ff, nxt_ret;
	logic [POS_WIDTH-1:0] cmd_ff, dev_ff, err_adj;
	logic code_on;

	// all opto inputs except start_inputs_any_in pass the synchroniser before use
	assign opto_raw = {stop_in, excite_on_in, current_control_select_in, deviation_clear_in,
		push_select_bit0_in, shared_bit2_in, shared_bit1_in, shared_sel_in};

	sdio_sync #(
		.W(NOPTO)
	) u_sync (
		.mclk_in(mclk_in),
		.rst_in(rst_in),
		.async_in(opto_raw),
		.level_out(opto_lvl),
		.rise_out(opto_rise),
		.fall_out(opto_fall)
	);

	assign sel_l = opto_lvl[0];
	assign b1_l = opto_lvl[1];
	assign b2_l = opto_lvl[2];
	assign clr_l = opto_lvl[4];
	assign ccm_l = opto_lvl[5];
	assign exc_l = opto_lvl[6];
	assign stp_l = opto_lvl[7];
	assign sel_r = opto_rise[0];
	assign b1_r = opto_rise[1];
	assign b2_r = opto_rise[2];
	assign clr_r = opto_rise[4];
	assign clr_f = opto_fall[4];

	// shared pins change meaning with the input mode
	assign push_mode = (io_mode_in == IO_MODE_PUSH);

	// lock switch pins resolution to the second table
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			resolution_second_out <= RES_SEL_FIRST;
		end else if (resolution_lock_switch_in) begin
			resolution_second_out <= RES_SEL_SECOND;
		end else if (!push_mode) begin
			resolution_second_out <= sel_l;
		end
	end

	// push current selection; in push mode the select pin is the push current mode input
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			push_current_active_out <= 1'h0;
			push_select_out <= '0;
		end else begin
			push_current_active_out <= push_mode & sel_l;
			push_select_out <= push_mode ? {b2_l, b1_l, opto_lvl[3]} : '0;
		end
	end

	// current control mode; host changes it only at standstill, so no motion interlock here
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			current_control_mode_out <= 1'h0;
		end else begin
			current_control_mode_out <= ccm_l & ~current_mode_disable_switch_in;
		end
	end

	// resolution select asserted with the warning enabled blocks homing until a preset
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ret_block_ff <= 1'h0;
		end else if (!push_mode && sel_r && abnormal_data_warn_enable_in) begin
			ret_block_ff <= 1'h1;
		end else if (!push_mode && b2_r) begin
			ret_block_ff <= 1'h0;
		end
	end

	// return-to-home sequencing
	always_comb begin
		nxt_ret = ret_ff;
		unique case (ret_ff)
			SDIO_RET_IDLE: begin
				if (!push_mode && b1_r && !clr_l) begin
					nxt_ret = ret_block_ff ? SDIO_RET_BLOCK : SDIO_RET_RUN;
				end
			end
			SDIO_RET_RUN: begin
				if (clr_l || home_reached_in || (cmd_ff == HOME_POS[POS_WIDTH-1:0])) begin
					nxt_ret = SDIO_RET_IDLE;
				end
			end
			SDIO_RET_BLOCK: begin
				nxt_ret = SDIO_RET_IDLE;
			end
			default: nxt_ret = SDIO_RET_IDLE;
		endcase
	end

	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ret_ff <= SDIO_RET_IDLE;
		end else begin
			ret_ff <= nxt_ret;
		end
	end

	assign go_home_run_out = (ret_ff == SDIO_RET_RUN);
	// abort is a level so the motor side drops auto return too
	assign abort_return_out = clr_l & (go_home_run_out | auto_return_active_in);

	// accumulated command position; pulses are dropped while clear is held
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			cmd_ff <= '0;
		end else if (!push_mode && b2_r) begin
			cmd_ff <= HOME_POS[POS_WIDTH-1:0];
		end else if (step_pulse_in && !clr_l) begin
			cmd_ff <= step_dir_in ? cmd_ff + 1'b1 : cmd_ff - 1'b1;
		end
	end
	assign command_pos_out = cmd_ff;

	// deviation counter: forward pulses raise it, forward motor ticks lower it, reverse the opposite
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			dev_ff <= '0;
		end else if (clr_r || clr_l) begin
			dev_ff <= '0;
		end else if (step_pulse_in && !motor_tick_in) begin
			dev_ff <= step_dir_in ? dev_ff + 1'b1 : dev_ff - 1'b1;
		end else if (motor_tick_in && !step_pulse_in) begin
			dev_ff <= motor_dir_in ? dev_ff - 1'b1 : dev_ff + 1'b1;
		end
	end
	assign deviation_out = dev_ff;

	// alarm latch; a new event wins over a reset edge in the same cycle
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_ff <= 1'h0;
			alarm_resettable_ff <= 1'h0;
		end else if (alarm_event_in) begin
			alarm_ff <= 1'h1;
			alarm_resettable_ff <= alarm_resettable_in;
		end else if (clr_f && alarm_resettable_ff) begin
			alarm_ff <= 1'h0;
		end
	end

	// data-kind alarms keep the current flowing
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			motor_current_cut_out <= 1'h0;
		end else if (alarm_event_in) begin
			motor_current_cut_out <= ~alarm_data_kind_in;
		end else if (!alarm_ff) begin
			motor_current_cut_out <= 1'h0;
		end
	end

	assign code_on = alarm_ff & (alarm_code_enable_in == ALM_CODE_ENABLE);

	// status lines; alarm code overrides the shared three
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			ready_out <= 1'h0;
			torque_limit_flag_out <= 1'h0;
			step_timing_oc_out <= 1'h0;
		end else if (code_on) begin
			ready_out <= alarm_cause_in[0];
			torque_limit_flag_out <= alarm_cause_in[1];
			step_timing_oc_out <= alarm_cause_in[2];
		end else begin
			ready_out <= power_good_in & ~start_inputs_any_in & exc_l & ~stp_l
				& ~alarm_ff & ~tool_busy_in;
			torque_limit_flag_out <= torque_over_in | (push_current_active_out & pushing_in);
			step_timing_oc_out <= tim_mark_in & tim_oc_ok_in;
		end
	end

	// line-driver timing output is rate limited separately
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			step_timing_line_out <= 1'h0;
		end else begin
			step_timing_line_out <= tim_mark_in & tim_line_ok_in;
		end
	end

	// completion window compares the offset-corrected error against a symmetric band
	assign err_adj = rotor_error_in - end_offset_in;
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			move_done_out <= 1'h0;
		end else begin
			move_done_out <= ~pulse_active_in & (($signed(err_adj) <= $signed(end_window_in))
				&& ($signed(err_adj) >= -$signed(end_window_in)));
		end
	end

	// gray-coded quadrature: each motor tick advances one quarter cycle
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			quad_ff <= 2'h0;
		end else if (motor_tick_in) begin
			quad_ff <= motor_dir_in ? quad_ff + 2'h1 : quad_ff - 2'h1;
		end
	end
	assign feedback_phase_a_out = quad_ff[1] ^ quad_ff[0];
	assign feedback_phase_b_out = quad_ff[1];

	// alarm output active low, warning when its condition is reported or a go-home request is blocked
	always_ff @(posedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			alarm_n_out <= 1'h1;
			warning_flag_out <= 1'h0;
		end else begin
			alarm_n_out <= ~alarm_ff;
			warning_flag_out <= warning_cond_in | (ret_ff == SDIO_RET_BLOCK);
		end
	end
endmodule
`default_nettype wire

// ### sdio_top_props.sv
/*
 port-level assertions for the stepper driver control i/o block.
 assumes one clock, asynchronous high reset, and the registered output timing of the design.
*/
`timescale 1ns/100ps
`default_nettype none
module sdio_top_props
	import sdio_pkg::*;
#(
	parameter int POS_WIDTH = POS_W
) (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic shared_bit2_in,
	input wire logic deviation_clear_in,
	input wire logic io_mode_in,
	input wire logic alarm_code_enable_in,
	input wire logic torque_over_in,
	input wire logic alarm_event_in,
	input wire logic alarm_resettable_in,
	input wire logic alarm_data_kind_in,
	input wire logic [ALM_CODE_W-1:0] alarm_cause_in,
	input wire logic warning_cond_in,
	input wire logic motor_dir_in,
	input wire logic go_home_run_out,
	input wire logic motor_current_cut_out,
	input wire logic [POS_WIDTH-1:0] command_pos_out,
	input wire logic [POS_WIDTH-1:0] deviation_out,
	input wire logic ready_out,
	input wire logic torque_limit_flag_out,
	input wire logic step_timing_oc_out,
	input wire logic feedback_phase_a_out,
	input wire logic feedback_phase_b_out,
	input wire logic alarm_n_out,
	input wire logic warning_flag_out
);
	// every check runs on the core clock and is muted during reset
	default clocking cb @(posedge mclk_in);
	endclocking
	default disable iff (rst_in);
	// held clear lets the sync chain settle, after which the counter must sit at zero
	AST_DEV_CLEAR: assert property (deviation_clear_in [*4] |-> deviation_out == '0)
		else $error("deviation not zero under clear");
	AST_ABORT_HOME: assert property (deviation_clear_in [*4] |-> !go_home_run_out)
		else $error("homing runs under clear");
	AST_ALARM_RESET: assert property (!alarm_n_out && alarm_resettable_in && !alarm_event_in
		&& $fell(deviation_clear_in) |-> ##[2:5] alarm_n_out)
		else $error("alarm not reset on clear release");
	AST_ALARM_CUT: assert property (alarm_event_in && !alarm_data_kind_in
		|-> ##[1:2] !alarm_n_out && motor_current_cut_out)
		else $error("alarm did not cut current");
	AST_ALARM_CODE: assert property (!alarm_n_out && !$past(alarm_n_out)
		&& $past(alarm_code_enable_in) && $stable(alarm_cause_in)
		|-> {step_timing_oc_out, torque_limit_flag_out, ready_out} == alarm_cause_in)
		else $error("alarm code wrong on status lines");
	AST_TORQUE: assert property ($past(torque_over_in) && alarm_n_out |-> torque_limit_flag_out)
		else $error("torque flag missing");
	AST_WARN: assert property ($past(warning_cond_in) |-> warning_flag_out)
		else $error("warning flag missing");
	AST_QUAD_DIR: assert property ($rose(feedback_phase_a_out)
		|-> feedback_phase_b_out == !$past(motor_dir_in))
		else $error("phase b level wrong at rise of a");
	AST_PRESET: assert property (io_mode_in == IO_MODE_POSITION && $rose(shared_bit2_in)
		|-> ##[2:5] command_pos_out == HOME_POS)
		else $error("preset did not zero command position");
endmodule
bind sdio_top sdio_top_props #(.POS_WIDTH(POS_WIDTH)) u_props (.*);
`default_nettype wire

// ### sdio_host.sv
/*
 host controller model: issues step strobes towards the driver.
 assumes the driver's ready level on the same clock; direction fixed forward.
*/
`timescale 1ns/100ps
`default_nettype none
module sdio_host (
	input wire logic mclk_in,
	input wire logic rst_in,
	input wire logic en_in,
	input wire logic ready_in,
	output logic step_pulse_out,
	output logic step_dir_out
);
	logic [1:0] gap_ff;
	// one strobe every fourth cycle; a host that ignores ready would lose steps
	always_ff @(negedge mclk_in or posedge rst_in) begin
		if (rst_in) begin
			gap_ff <= 2'h0;
			step_pulse_out <= 1'h0;
		end else begin
			gap_ff <= gap_ff + 2'h1;
			step_pulse_out <= en_in && ready_in && gap_ff == 2'h0;
		end
	end
	assign step_dir_out = 1'h1;
endmodule
`default_nettype wire

// ### sdio_top_tb.sv
/*
 self-checking bench for the stepper driver control i/o block.
 assumes inputs driven at the falling edge and a few cycles of sync latency.
*/
`timescale 1ns/100ps
`default_nettype none
module sdio_top_tb;
	logic mclk_in, rst_in, shared_sel_in, shared_bit1_in, shared_bit2_in, push_select_bit0_in;
	logic deviation_clear_in, current_control_select_in, excite_on_in, stop_in;
	logic start_inputs_any_in, resolution_lock_switch_in, current_mode_disable_switch_in;
	logic io_mode_in, alarm_code_enable_in, abnormal_data_warn_enable_in, power_good_in;
	logic tool_busy_in, step_pulse_in, step_dir_in, pulse_active_in, torque_over_in, pushing_in;
	logic alarm_event_in, alarm_resettable_in, alarm_data_kind_in, warning_cond_in;
	logic motor_tick_in, motor_dir_in, auto_return_active_in, home_reached_in, tim_mark_in;
	logic tim_line_ok_in, tim_oc_ok_in, host_en;
	logic [31:0] rotor_error_in, end_window_in, end_offset_in, command_pos_out, deviation_out;
	logic [2:0] alarm_cause_in, push_select_out;
	logic resolution_second_out, push_current_active_out, current_control_mode_out;
	logic go_home_run_out, abort_return_out, motor_current_cut_out, ready_out;
	logic torque_limit_flag_out, move_done_out, step_timing_line_out, step_timing_oc_out;
	logic feedback_phase_a_out, feedback_phase_b_out, alarm_n_out, warning_flag_out;
	logic [1:0] quad;
	logic [31:0] pos0;
	int fails, n_compared;
	sdio_top u_dut (.*);
	sdio_host u_host (.mclk_in, .rst_in, .en_in(host_en), .ready_in(ready_out),
		.step_pulse_out(step_pulse_in), .step_dir_out(step_dir_in));
	// free-running 200 MHz clock
	always #2.5 mclk_in = ~mclk_in;
	task cyc(input int n);
		repeat (n) @(negedge mclk_in);
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			fails++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task end_of_test();
		$display("compared %0d mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// bounded wait; a driver that never becomes ready ends the run
	task wait_ready();
		int i;
		for (i = 0; i < 50 && ready_out !== 1'h1; i++) cyc(1);
		chk(ready_out, 1);
		if (ready_out !== 1'h1) end_of_test();
	endtask
	task t_ready();
		stop_in = 1; cyc(5); chk(ready_out, 0);
		stop_in = 0; tool_busy_in = 1; cyc(5); chk(ready_out, 0);
		tool_busy_in = 0; start_inputs_any_in = 1; cyc(5); chk(ready_out, 0);
		start_inputs_any_in = 0; cyc(5); chk(ready_out, 1);
		$display("ready test done");
	endtask
	task t_res();
		// the host only moves the select line with the timing mark on and the motor still
		tim_mark_in = 1;
		for (int v = 0; v < 2; v++) begin
			shared_sel_in = v[0]; cyc(5); chk(resolution_second_out, v);
		end
		shared_sel_in = 0; resolution_lock_switch_in = 1; cyc(5);
		chk(resolution_second_out, 1);
		resolution_lock_switch_in = 0; cyc(5);
		$display("resolution test done");
	endtask
	task t_home();
		host_en = 1; cyc(40); host_en = 0; cyc(5);
		chk(command_pos_out !== 32'h0, 1);
		shared_bit1_in = 1; cyc(5); chk(go_home_run_out, 1);
		deviation_clear_in = 1; cyc(5); chk(go_home_run_out, 0);
		chk(deviation_out, 0);
		auto_return_active_in = 1;
		cyc(1);
		chk(abort_return_out, 1);
		auto_return_active_in = 0;
		pos0 = command_pos_out;
		host_en = 1; cyc(20); chk(deviation_out, 0);
		chk(command_pos_out, pos0);
		host_en = 0; shared_bit1_in = 0; deviation_clear_in = 0; cyc(5);
		shared_bit2_in = 1; cyc(5); chk(command_pos_out, 0);
		shared_bit2_in = 0; cyc(5);
		$display("home test done");
	endtask
	task t_block();
		abnormal_data_warn_enable_in = 1; tim_mark_in = 1;
		shared_sel_in = 1; cyc(5);
		shared_bit1_in = 1;
		// the refused request shows as a one-cycle warning four edges after the pin
		cyc(4);
		chk(warning_flag_out, 1);
		cyc(1);
		chk(go_home_run_out, 0);
		shared_bit1_in = 0; shared_sel_in = 0; abnormal_data_warn_enable_in = 0; cyc(5);
		shared_bit2_in = 1; cyc(5); shared_bit2_in = 0;
		host_en = 1; cyc(20); host_en = 0; cyc(5);
		shared_bit1_in = 1; cyc(5); chk(go_home_run_out, 1);
		shared_bit1_in = 0; deviation_clear_in = 1; cyc(5); deviation_clear_in = 0; cyc(5);
		$display("block test done");
	endtask
	task t_push();
		io_mode_in = 1;
		for (int k = 0; k < 8; k++) begin
			{shared_bit2_in, shared_bit1_in, push_select_bit0_in} = k[2:0]; cyc(5);
			chk(push_select_out, k);
			chk(go_home_run_out, 0);
		end
		chk(command_pos_out !== 32'h0, 1);
		shared_sel_in = 1; cyc(5); chk(push_current_active_out, 1);
		chk(resolution_second_out, 0);
		{shared_sel_in, shared_bit2_in, shared_bit1_in, push_select_bit0_in} = 4'h0; cyc(5);
		io_mode_in = 0; cyc(5);
		$display("push test done");
	endtask
	task t_ccm();
		current_mode_disable_switch_in = 1; current_control_select_in = 1; cyc(5);
		chk(current_control_mode_out, 0);
		current_control_select_in = 0; cyc(5); current_mode_disable_switch_in = 0;
		current_control_select_in = 1; cyc(5); chk(current_control_mode_out, 1);
		current_control_select_in = 0; cyc(5); chk(current_control_mode_out, 0);
		$display("current mode test done");
	endtask
	task t_alarm();
		alarm_code_enable_in = 1; alarm_cause_in = 3'h5; alarm_resettable_in = 1;
		alarm_event_in = 1; cyc(1); alarm_event_in = 0; cyc(3);
		chk(alarm_n_out, 0);
		chk(motor_current_cut_out, 1);
		chk({step_timing_oc_out, torque_limit_flag_out, ready_out}, 5);
		deviation_clear_in = 1; cyc(5); chk(alarm_n_out, 0);
		deviation_clear_in = 0; cyc(5); chk(alarm_n_out, 1);
		alarm_data_kind_in = 1; alarm_event_in = 1; cyc(1); alarm_event_in = 0; cyc(3);
		chk(motor_current_cut_out, 0);
		deviation_clear_in = 1; cyc(5); deviation_clear_in = 0; cyc(5);
		alarm_data_kind_in = 0; alarm_code_enable_in = 0;
		$display("alarm test done");
	endtask
	task t_misc();
		torque_over_in = 1; cyc(3); chk(torque_limit_flag_out, 1);
		// pushing only counts once a push current is selected in push-motion mode
		torque_over_in = 0;
		io_mode_in = 1;
		shared_sel_in = 1;
		pushing_in = 1;
		cyc(5);
		chk(torque_limit_flag_out, 1);
		pushing_in = 0;
		shared_sel_in = 0;
		warning_cond_in = 1; cyc(3); chk(warning_flag_out, 1);
		io_mode_in = 0;
		warning_cond_in = 0; tim_line_ok_in = 1; tim_oc_ok_in = 1; cyc(3);
		chk(step_timing_line_out, 1);
		chk(step_timing_oc_out, 1);
		end_window_in = 32'h10; rotor_error_in = 32'h0; cyc(3); chk(move_done_out, 1);
		pulse_active_in = 1; cyc(3); chk(move_done_out, 0);
		pulse_active_in = 0;
		rotor_error_in = 32'h11;
		cyc(3);
		chk(move_done_out, 0);
		rotor_error_in = 32'h0;
		quad = {feedback_phase_a_out, feedback_phase_b_out};
		for (int d = 0; d < 8; d++) begin
			motor_dir_in = d < 4;
			motor_tick_in = 1;
			cyc(1);
			motor_tick_in = 0;
			// first forward tick from rest: phase a leads, b still low
			if (d == 0) chk({feedback_phase_a_out, feedback_phase_b_out}, 2'h2);
			cyc(1);
		end
		chk({feedback_phase_a_out, feedback_phase_b_out}, quad);
		$display("status test done");
	endtask
	// reset for 8 cycles, then the scenarios in turn
	initial begin
		{mclk_in, shared_sel_in, shared_bit1_in, shared_bit2_in, push_select_bit0_in,
			deviation_clear_in, current_control_select_in, stop_in, start_inputs_any_in,
			resolution_lock_switch_in, current_mode_disable_switch_in, io_mode_in,
			alarm_code_enable_in, abnormal_data_warn_enable_in, tool_busy_in, pulse_active_in,
			torque_over_in, pushing_in, alarm_event_in, alarm_resettable_in, alarm_data_kind_in,
			warning_cond_in, motor_tick_in, motor_dir_in, auto_return_active_in,
			home_reached_in, tim_mark_in, tim_line_ok_in, tim_oc_ok_in, host_en} = '0;
		{rotor_error_in, end_window_in, end_offset_in, alarm_cause_in} = '0;
		fails = 0; n_compared = 0;
		power_good_in = 1; excite_on_in = 1; rst_in = 1;
		cyc(8); rst_in = 0;
		wait_ready();
		t_ready(); t_res(); t_home(); t_block(); t_push(); t_ccm(); t_alarm(); t_misc();
		end_of_test();
	end
endmodule
`default_nettype wire
